// [inc/lld_map.svh]
`ifndef LLD_MAP_SVH
`define LLD_MAP_SVH
// Register byte offsets on the APB side.
`define LLD_OFF_GCS 8'h00
`define LLD_OFF_XCTL 8'h04
`define LLD_OFF_VADDR 8'h08
`define LLD_OFF_LADDR 8'h0C
`define LLD_OFF_COUNT 8'h10
`define LLD_OFF_PTR 8'h14
`define LLD_OFF_LOCK 8'h18
// Field positions inside the general control/status register.
`define LLD_GCS_GO 0
`define LLD_GCS_STOPREQ 1
`define LLD_GCS_HALTREQ 2
`define LLD_GCS_CHAIN 3
`define LLD_GCS_RUN 7
`define LLD_GCS_ST_LO 8
`define LLD_GCS_ST_HI 13
`define LLD_GCS_IE_LO 16
`define LLD_GCS_IE_HI 21
// Positions inside the six-bit termination status field.
`define LLD_ST_DONE 0
`define LLD_ST_STOP 1
`define LLD_ST_HALT 2
`define LLD_ST_LERR 3
`define LLD_ST_VERR 4
`define LLD_ST_PERR 5
`define LLD_ST_NONE 6'h00
`define LLD_ST_ERRS 6'h38
// List edit lock and packet layout.
`define LLD_LOCK_BIT 0
`define LLD_PKT_CONSUMED 0
`define LLD_PKT_LAST 1
`define LLD_PKT_CTL 3'h0
`define LLD_PKT_COUNT 3'h1
`define LLD_PKT_VADDR 3'h2
`define LLD_PKT_LADDR 3'h3
`define LLD_PKT_NEXT 3'h4
`define LLD_PKT_NEXT_OFF 32'h10
`define LLD_PTR_MASK 32'hFFFF_FFFC
// Data movement and timing.
`define LLD_WORD_BYTES 32'h4
`define LLD_BEAT_BYTES 32'h8
`define LLD_ALIGN_HI 2
`define LLD_RST_WORD 32'h0000_0000
`define LLD_CLK_NS 10
`define LLD_MARK_NS 1000
`define LLD_FIFO_ENTRIES 32
`endif

// [inc/lld_pkg.sv]
package lld_pkg;
	typedef enum logic [2:0] {
		LLD_IDLE = 3'h0,
		LLD_XFER = 3'h1,
		LLD_DRAIN = 3'h2,
		LLD_LOCK = 3'h3,
		LLD_FETCH = 3'h4,
		LLD_MARK = 3'h5,
		LLD_WAITP = 3'h6
	} lld_fsm_t;

	typedef struct packed {
		lld_fsm_t fsm;
		logic run;
		logic stop_req;
		logic halt_req;
		logic chain;
		logic [5:0] stat;
		logic [5:0] ien;
		logic [31:0] xctl;
		logic [31:0] vaddr;
		logic [31:0] laddr;
		logic [31:0] count;
		logic [31:0] ptr;
		logic [31:0] pkt_addr;
		logic [31:0] mark_addr;
		logic [31:0] mark_word;
		logic [31:0] maddr;
		logic [31:0] prdata;
		logic [2:0] idx;
		logic pkt_valid;
		logic hmark;
		logic lock_bit;
		logic lock_held;
	} lld_regs_t;

	typedef struct packed {
		logic busy;
		logic [7:0] cnt;
	} lld_tmr_t;

	typedef struct packed {
		logic [8:0] lvl;
	} lld_fill_t;
endpackage

// [rtl/lld_mark_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module lld_mark_timer #(
	parameter int CYCLES = 100
) (
	input wire logic sys_clk, // System clock.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic start, // One-cycle pulse that arms the delay.
	output logic expired // One-cycle pulse when the delay ends.
);
	localparam int CYC = CYCLES;
	lld_pkg::lld_tmr_t t_q, t_d;

	// The counter is eight bits wide, so longer delays are refused.
	if (CYCLES < 1 || CYCLES > 255) begin : g_chk
		$error("lld_mark_timer: CYCLES out of range");
	end

	// A new start simply re-arms the delay from the full count.
	always_comb
	begin
		t_d = t_q;
		if (start)
		begin
			t_d.busy = 1'b1;
			t_d.cnt = 8'(CYCLES - 1);
		end
		else if (t_q.busy)
		begin
			if (t_q.cnt == 8'h00)
				t_d.busy = 1'b0;
			else
				t_d.cnt = t_q.cnt - 8'h01;
		end
	end

	// State register.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			t_q <= '0;
		else
			t_q <= t_d;
	end

	assign expired = t_q.busy && (t_q.cnt == 8'h00);

	delay_exact_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		start |-> !expired [*1] ##CYC expired)
		else $error("Mark delay did not end on time.");
endmodule
`default_nettype wire

// [rtl/lld_fill_track.sv]
`timescale 1ns/100ps
`default_nettype none
module lld_fill_track #(
	parameter int DEPTH = 32
) (
	input wire logic sys_clk, // System clock.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic push, // One beat queued from the source bus.
	input wire logic pop, // One beat written to the destination bus.
	output logic full, // No room for another beat.
	output logic empty // Nothing queued.
);
	lld_pkg::lld_fill_t f_q, f_d;

	// The level is nine bits wide, so deeper queues are refused.
	if (DEPTH < 2 || DEPTH > 256) begin : g_chk
		$error("lld_fill_track: DEPTH out of range");
	end

	// Only occupancy is tracked; the data itself lives in the bus bridge.
	always_comb
	begin
		f_d = f_q;
		if (push && !pop)
			f_d.lvl = f_q.lvl + 9'h001;
		else if (pop && !push)
			f_d.lvl = f_q.lvl - 9'h001;
	end

	// State register.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			f_q <= '0;
		else
			f_q <= f_d;
	end

	assign full = (f_q.lvl == 9'(DEPTH));
	assign empty = (f_q.lvl == 9'h000);

	level_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
		f_q.lvl <= 9'(DEPTH))
		else $error("Queue level passed its depth.");
endmodule
`default_nettype wire

// [rtl/lld_sequencer.sv]
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "lld_map.svh"
module lld_sequencer #(
	parameter int MARK_CYCLES =
		(`LLD_MARK_NS + `LLD_CLK_NS - 1) / `LLD_CLK_NS,
	parameter int FIFO_DEPTH = `LLD_FIFO_ENTRIES
) (
	input wire logic sys_clk, // System clock, 100 MHz.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB write.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped addresses.
	output logic mem_req, // Packet memory request.
	output logic mem_we, // Packet memory write.
	output logic [31:0] mem_addr, // Packet memory byte address.
	output logic [31:0] mem_wdata, // Packet memory write data.
	input wire logic [31:0] mem_rdata, // Packet memory read data.
	input wire logic mem_ack, // Packet memory access done.
	output logic src_req, // Request one source-bus beat.
	input wire logic src_ack, // Source beat read and queued.
	output logic dst_req, // Queued data awaits the destination.
	input wire logic dst_ack, // Destination beat written.
	output logic [31:0] xfer_ctl, // Current transfer attributes.
	output logic [31:0] xfer_vaddr, // Next VMEbus-side address.
	output logic [31:0] xfer_laddr, // Next local-side address.
	input wire logic err_local, // Local-bus error pulse.
	input wire logic err_vme, // VMEbus error pulse.
	output logic term_irq // Enabled termination event pending.
);
	localparam int MK = MARK_CYCLES;
	lld_pkg::lld_regs_t s_q, s_d;
	logic apb_wr;
	logic go_ok;
	logic tmr_start;
	logic tmr_done;
	logic q_full;
	logic q_empty;
	logic packet_end;

	if (FIFO_DEPTH < 2) begin : g_chk
		$error("lld_sequencer: FIFO_DEPTH too small");
	end

	// Next source or destination address after one beat.
	function automatic logic [31:0] beat_next(input logic [31:0] a);
		return a + `LLD_BEAT_BYTES;
	endfunction

	// Decodes the mapped offsets; anything else is answered with an error.
	function automatic logic addr_ok(input logic [7:0] a);
		return a == `LLD_OFF_GCS || a == `LLD_OFF_XCTL ||
			a == `LLD_OFF_VADDR || a == `LLD_OFF_LADDR ||
			a == `LLD_OFF_COUNT || a == `LLD_OFF_PTR ||
			a == `LLD_OFF_LOCK;
	endfunction

	// Read multiplexer; reserved bits and unmapped words read as zero.
	function automatic logic [31:0] rd_word(input logic [7:0] a,
		input lld_pkg::lld_regs_t s);
		logic [31:0] w;
		w = `LLD_RST_WORD;
		case (a)
			`LLD_OFF_GCS:
			begin
				w[`LLD_GCS_STOPREQ] = s.stop_req;
				w[`LLD_GCS_HALTREQ] = s.halt_req;
				w[`LLD_GCS_CHAIN] = s.chain;
				w[`LLD_GCS_RUN] = s.run;
				w[`LLD_GCS_ST_HI:`LLD_GCS_ST_LO] = s.stat;
				w[`LLD_GCS_IE_HI:`LLD_GCS_IE_LO] = s.ien;
			end
			`LLD_OFF_XCTL: w = s.xctl;
			`LLD_OFF_VADDR: w = s.vaddr;
			`LLD_OFF_LADDR: w = s.laddr;
			`LLD_OFF_COUNT: w = s.count;
			`LLD_OFF_PTR: w = s.ptr;
			// claim read-back
			// While the device holds the lock the bit reads back as zero.
			`LLD_OFF_LOCK: w[`LLD_LOCK_BIT] = s.lock_bit && !s.lock_held;
			default: w = `LLD_RST_WORD;
		endcase
		return w;
	endfunction

	assign apb_wr = psel && penable && pwrite;
	assign packet_end = (s_q.count == `LLD_RST_WORD) && q_empty;

	// Register writes, then the sequencer; hardware sets land after
	// software clears, so an event in the clearing cycle is kept.
	always_comb
	begin
		s_d = s_q;
		if (psel && !penable)
			s_d.prdata = rd_word(paddr, s_q);
		if (apb_wr)
		begin
			case (paddr)
				`LLD_OFF_GCS:
				begin
					s_d.stop_req = pwdata[`LLD_GCS_STOPREQ];
					s_d.halt_req = pwdata[`LLD_GCS_HALTREQ];
					s_d.chain = pwdata[`LLD_GCS_CHAIN];
					s_d.ien = pwdata[`LLD_GCS_IE_HI:`LLD_GCS_IE_LO];
					s_d.stat = s_q.stat &
						~pwdata[`LLD_GCS_ST_HI:`LLD_GCS_ST_LO];
				end
				`LLD_OFF_XCTL: s_d.xctl = pwdata;
				`LLD_OFF_VADDR: s_d.vaddr = pwdata;
				`LLD_OFF_LADDR: s_d.laddr = pwdata;
				`LLD_OFF_COUNT: s_d.count = pwdata;
				`LLD_OFF_PTR: s_d.ptr = pwdata;
				`LLD_OFF_LOCK:
					if (!s_q.lock_held)
						s_d.lock_bit = pwdata[`LLD_LOCK_BIT];
				default: s_d.ien = s_q.ien;
			endcase
		end
		go_ok = apb_wr && (paddr == `LLD_OFF_GCS) &&
			pwdata[`LLD_GCS_GO] && (s_q.fsm == lld_pkg::LLD_IDLE) &&
			(s_d.stat == `LLD_ST_NONE);
		case (s_q.fsm)
			lld_pkg::LLD_IDLE:
			begin
				if (go_ok)
				begin
					if (s_q.count != `LLD_RST_WORD &&
						s_q.vaddr[`LLD_ALIGN_HI:0] != s_q.laddr[`LLD_ALIGN_HI:0])
						s_d.stat[`LLD_ST_PERR] = 1'b1;
					else if (s_q.count != `LLD_RST_WORD)
					begin
						s_d.run = 1'b1;
						s_d.fsm = lld_pkg::LLD_XFER;
					end
					else if (s_q.chain)
					begin
						s_d.run = 1'b1;
						s_d.pkt_valid = 1'b0;
						s_d.hmark = 1'b0;
						s_d.fsm = lld_pkg::LLD_LOCK;
					end
					else
						s_d.stat[`LLD_ST_DONE] = 1'b1;
				end
			end
			lld_pkg::LLD_XFER:
			begin
				if (src_ack)
				begin
					s_d.vaddr = beat_next(s_q.vaddr);
					s_d.laddr = beat_next(s_q.laddr);
					s_d.count = (s_q.count > `LLD_BEAT_BYTES) ?
						s_q.count - `LLD_BEAT_BYTES : `LLD_RST_WORD;
				end
				if (err_local || err_vme)
				begin
					s_d.stat[`LLD_ST_LERR] = s_q.stat[`LLD_ST_LERR] || err_local;
					s_d.stat[`LLD_ST_VERR] = s_q.stat[`LLD_ST_VERR] || err_vme;
					s_d.run = 1'b0;
					s_d.fsm = lld_pkg::LLD_IDLE;
				end
				else if (s_q.stop_req)
					s_d.fsm = lld_pkg::LLD_DRAIN;
				else if (packet_end)
				begin
					s_d.mark_addr = s_q.pkt_addr + `LLD_PKT_NEXT_OFF;
					s_d.mark_word = s_q.ptr;
					s_d.mark_word[`LLD_PKT_CONSUMED] = 1'b1;
					s_d.maddr = s_q.pkt_addr + `LLD_PKT_NEXT_OFF;
					if (!s_q.chain)
					begin
						s_d.stat[`LLD_ST_DONE] = 1'b1;
						s_d.run = 1'b0;
						s_d.fsm = lld_pkg::LLD_IDLE;
					end
					else if (!s_q.pkt_valid)
						s_d.fsm = lld_pkg::LLD_LOCK;
					else if (s_q.halt_req && !s_q.ptr[`LLD_PKT_LAST])
					begin
						s_d.hmark = 1'b1;
						s_d.fsm = lld_pkg::LLD_LOCK;
					end
					else
						s_d.fsm = lld_pkg::LLD_MARK;
				end
			end
			lld_pkg::LLD_DRAIN:
			begin
				if (q_empty)
				begin
					s_d.stat[`LLD_ST_STOP] = 1'b1;
					s_d.stop_req = 1'b0;
					s_d.run = 1'b0;
					s_d.fsm = lld_pkg::LLD_IDLE;
				end
			end
			lld_pkg::LLD_LOCK:
			begin
				if (!s_q.lock_bit)
				begin
					s_d.lock_held = 1'b1;
					s_d.maddr = s_q.ptr & `LLD_PTR_MASK;
					s_d.idx = `LLD_PKT_CTL;
					s_d.fsm = lld_pkg::LLD_FETCH;
				end
			end
			lld_pkg::LLD_FETCH:
			begin
				if (mem_ack)
				begin
					s_d.maddr = s_q.maddr + `LLD_WORD_BYTES;
					s_d.idx = s_q.idx + 3'h1;
					case (s_q.idx)
						`LLD_PKT_CTL: s_d.xctl = mem_rdata;
						`LLD_PKT_COUNT: s_d.count = mem_rdata;
						`LLD_PKT_VADDR: s_d.vaddr = mem_rdata;
						`LLD_PKT_LADDR: s_d.laddr = mem_rdata;
						default: s_d.ptr = mem_rdata;
					endcase
					if (s_q.idx == `LLD_PKT_NEXT)
					begin
						s_d.lock_held = 1'b0;
						s_d.pkt_addr = s_q.ptr & `LLD_PTR_MASK;
						s_d.pkt_valid = 1'b1;
						s_d.fsm = lld_pkg::LLD_XFER;
						if (s_q.hmark)
						begin
							s_d.stat[`LLD_ST_HALT] = 1'b1;
							s_d.halt_req = 1'b0;
							s_d.run = 1'b0;
							s_d.fsm = lld_pkg::LLD_WAITP;
						end
					end
				end
			end
			lld_pkg::LLD_WAITP:
			begin
				if (tmr_done)
				begin
					s_d.maddr = s_q.mark_addr;
					s_d.fsm = lld_pkg::LLD_MARK;
				end
			end
			lld_pkg::LLD_MARK:
			begin
				if (mem_ack)
				begin
					s_d.hmark = 1'b0;
					s_d.fsm = lld_pkg::LLD_LOCK;
					if (s_q.hmark || s_q.ptr[`LLD_PKT_LAST])
					begin
						s_d.stat[`LLD_ST_DONE] = !s_q.hmark;
						s_d.run = 1'b0;
						s_d.fsm = lld_pkg::LLD_IDLE;
					end
				end
			end
			default: s_d.fsm = lld_pkg::LLD_IDLE;
		endcase
	end

	// State register; every field starts from zero.
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// The delay is armed on the cycle the pause completes.
	assign tmr_start = (s_d.fsm == lld_pkg::LLD_WAITP) &&
		(s_q.fsm != lld_pkg::LLD_WAITP);

	lld_mark_timer #(
		.CYCLES(MARK_CYCLES)
	) u_timer (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.start(tmr_start),
		.expired(tmr_done)
	);

	lld_fill_track #(
		.DEPTH(FIFO_DEPTH)
	) u_fill (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.push(src_ack),
		.pop(dst_ack),
		.full(q_full),
		.empty(q_empty)
	);

	// Zero-wait APB: read data is captured in the setup cycle.
	assign prdata = s_q.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok(paddr);
	assign src_req = (s_q.fsm == lld_pkg::LLD_XFER) && !s_q.stop_req &&
		(s_q.count != `LLD_RST_WORD) && !q_full;
	assign dst_req = !q_empty;
	assign mem_req = (s_q.fsm == lld_pkg::LLD_FETCH) ||
		(s_q.fsm == lld_pkg::LLD_MARK);
	assign mem_we = (s_q.fsm == lld_pkg::LLD_MARK);
	assign mem_addr = s_q.maddr;
	assign mem_wdata = s_q.mark_word;
	assign xfer_ctl = s_q.xctl;
	assign xfer_vaddr = s_q.vaddr;
	assign xfer_laddr = s_q.laddr;
	assign term_irq = |(s_q.stat & s_q.ien);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	term_stops_run_a: assert property (
		$rose(|s_q.stat) |-> !s_q.run)
		else $error("Termination left running set.");
	halt_after_load_a: assert property (
		$rose(s_q.stat[`LLD_ST_HALT]) |-> $past(s_q.fsm) == lld_pkg::LLD_FETCH)
		else $error("Pause flagged before packet load.");
	mark_delay_a: assert property (
		$rose(s_q.stat[`LLD_ST_HALT]) |-> ##MK s_q.fsm == lld_pkg::LLD_MARK)
		else $error("Consumed write not one delay after pause.");
	launch_runs_a: assert property (
		go_ok |=> s_q.run || s_q.stat[`LLD_ST_PERR] || s_q.stat[`LLD_ST_DONE])
		else $error("Accepted launch did not start.");
	abort_quiet_a: assert property (
		(s_q.fsm == lld_pkg::LLD_DRAIN || s_q.stop_req) |->
		!src_req)
		else $error("Source active during abort.");
	stop_after_drain_a: assert property (
		$rose(s_q.stat[`LLD_ST_STOP]) |-> q_empty &&
		$past(s_q.fsm) == lld_pkg::LLD_DRAIN)
		else $error("Abort flagged with data queued.");
	list_start_a: assert property (
		go_ok && s_q.count == `LLD_RST_WORD && s_q.chain |=>
		s_q.fsm == lld_pkg::LLD_LOCK ##1 s_q.fsm != lld_pkg::LLD_XFER)
		else $error("List launch did not go to fetch.");
	list_end_a: assert property (
		s_q.fsm == lld_pkg::LLD_MARK && mem_ack && !s_q.hmark &&
		s_q.ptr[`LLD_PKT_LAST] |=> s_q.stat[`LLD_ST_DONE] && !s_q.run)
		else $error("List end not completed.");
	lock_take_a: assert property (
		s_q.fsm == lld_pkg::LLD_LOCK && !s_q.lock_bit |=>
		s_q.lock_held && s_q.fsm == lld_pkg::LLD_FETCH)
		else $error("Free lock not taken.");
	lock_stall_a: assert property (
		s_q.fsm == lld_pkg::LLD_LOCK && s_q.lock_bit && !apb_wr |=>
		s_q.fsm == lld_pkg::LLD_LOCK)
		else $error("Fetch went past a held lock.");
	mark_flag_a: assert property (
		mem_req && mem_we |-> mem_wdata[`LLD_PKT_CONSUMED])
		else $error("Consumed write without its bit.");
	lock_release_a: assert property (
		s_q.fsm == lld_pkg::LLD_FETCH && mem_ack &&
		s_q.idx == `LLD_PKT_NEXT |=> !s_q.lock_held)
		else $error("Lock kept after packet load.");
	err_clear_a: assert property (
		$rose(s_q.run) |-> (s_q.stat & `LLD_ST_ERRS) == `LLD_ST_NONE)
		else $error("Started with an error bit set.");
endmodule
`default_nettype wire

// [tb/lld_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Far side of the sequencer: packet memory and the two data buses.
module lld_far_model (
	input wire logic sys_clk, // System clock.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic [2:0] stall, // Random stall per bus.
	input wire logic mem_req, // Packet memory request.
	input wire logic mem_we, // Packet memory write.
	input wire logic [31:0] mem_addr, // Packet memory byte address.
	input wire logic [31:0] mem_wdata, // Packet memory write data.
	output logic [31:0] mem_rdata, // Packet memory read data.
	output logic mem_ack, // Word access done.
	input wire logic src_req, // Source beat wanted.
	output logic src_ack, // Source beat given.
	input wire logic dst_req, // Destination beat waiting.
	output logic dst_ack // Destination beat taken.
);
	logic [31:0] mem_q [0:63];
	logic [31:0] junk_q;
	// Answers follow their requests, so an ack never outlives a request.
	assign mem_ack = mem_req & ~stall[0];
	assign src_ack = src_req & ~stall[1];
	assign dst_ack = dst_req & ~stall[2];
	// Without an ack the bus shows a changing pattern, never stale data.
	assign mem_rdata = mem_ack ? mem_q[mem_addr[7:2]] : junk_q;
	// A write lands at the edge where the device takes its ack.
	always @(posedge sys_clk or negedge rst_b)
		if (!rst_b)
			junk_q <= 32'h5A5A_C3C3;
		else
		begin
			junk_q <= ~junk_q ^ mem_addr;
			if (mem_ack && mem_we)
				mem_q[mem_addr[7:2]] <= mem_wdata;
		end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lld_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	localparam int MC = 4;
	localparam logic [31:0] E = 32'h003F_0008;
	localparam logic [7:0] G = `LLD_OFF_GCS;
	localparam logic [7:0] P = `LLD_OFF_PTR;
	localparam logic [7:0] L = `LLD_OFF_LOCK;
	logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata;
	logic mem_req, mem_we, mem_ack, src_req, src_ack, dst_req, dst_ack;
	logic [31:0] xfer_ctl, xfer_vaddr, xfer_laddr, seed;
	logic err_local, err_vme, term_irq;
	logic [2:0] stall;
	logic [32:0] exp_q [$];
	logic [32:0] e33;
	int n_errors, checked, cyc, beats, n, b0;

	lld_sequencer #(.MARK_CYCLES(MC), .FIFO_DEPTH(4)) DUT (
		.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .src_req(src_req),
		.src_ack(src_ack), .dst_req(dst_req), .dst_ack(dst_ack),
		.xfer_ctl(xfer_ctl), .xfer_vaddr(xfer_vaddr),
		.xfer_laddr(xfer_laddr),
		.err_local(err_local), .err_vme(err_vme), .term_irq(term_irq));
	lld_far_model far (
		.sys_clk(sys_clk), .rst_b(rst_b), .stall(stall),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.src_req(src_req), .src_ack(src_ack), .dst_req(dst_req),
		.dst_ack(dst_ack));

	// The clock toggles every half period of 10 ns.
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Random stalls make every far-side answer sometimes prompt, sometimes slow.
	always @(posedge sys_clk)
	begin
		stall <= 3'($random(seed));
		cyc <= cyc + 1;
		if (src_ack === 1'b1)
			beats <= beats + 1;
		if (cyc == 30000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end

	// Each read answer is matched with the oldest expectation noted.
	always @(posedge sys_clk)
		if (psel && penable && pready && !pwrite && exp_q.size() > 0)
		begin
			e33 = exp_q.pop_front();
			`CHK({pslverr, prdata}, e33) // register readback
		end

	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back({1'b0, e});
		apb(1'b0, a, 32'h0);
	endtask

	// bounded completion wait
	// Waiting on the enabled-event level is bounded, so a hang shows up.
	task automatic wait_irq();
		int k;
		k = 0;
		while (term_irq !== 1'b1 && k < 3000)
		begin
			@(posedge sys_clk);
			k++;
		end
		`CHK(term_irq, 1'b1) // termination seen
	endtask

	// next word flags
	// The control word carries the packet's own address, so a load shows.
	task automatic mkpkt(input int p, input logic [31:0] cnt, nxt,
		input logic last);
		far.mem_q[p / 4] = 32'h0001_0000 + p;
		far.mem_q[p / 4 + 1] = cnt;
		far.mem_q[p / 4 + 2] = 32'h1000 + p * 16;
		far.mem_q[p / 4 + 3] = 32'h8000 + p * 16;
		far.mem_q[p / 4 + 4] = nxt | {30'h0, last, 1'b0};
	endtask

	function automatic logic cons(input int p);
		return far.mem_q[p / 4 + 4][0];
	endfunction

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Main sequence; each group leaves the device idle for the next one.
	initial
	begin
		seed = 32'h4b2ca203;
		{rst_b, psel, penable, pwrite, err_local, err_vme} = 6'h00;
		{paddr, pwdata, stall} = '0;
		{n_errors, checked, cyc, beats} = '0;
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		for (int a = 0; a < 28; a += 4)
			rd(8'(a), 32'h0); // reset values
		exp_q.push_back({1'b1, 32'h0});
		apb(1'b0, 8'h1C, 32'h0);
		$display("test registers done");
		mkpkt(0, 32'h40, 32'h20, 1'b0);
		mkpkt(32'h20, 32'h18, 32'h40, 1'b1);
		wr(G, E);
		wr(G, E | 32'h1);
		wait_irq();
		rd(G, E | 32'h100); // done flag
		`CHK(cons(0) & cons(32'h20), 1'b1) // consumed bits
		`CHK(far.mem_q[12], 32'h43) // flag positions
		`CHK(xfer_laddr, 32'h8218) // list order
		`CHK(xfer_ctl, 32'h0001_0020) // last packet loaded
		$display("test list walk done");
		mkpkt(32'h40, 32'h100, 32'h60, 1'b0);
		mkpkt(32'h60, 32'h100, 32'h80, 1'b1);
		wr(G, E | 32'h3F00);
		wr(P, 32'h40);
		wr(G, E | 32'h5);
		wait_irq();
		`CHK(cons(32'h40), 1'b0) // mark delayed
		`CHK(xfer_vaddr, 32'h1600) // next loaded
		rd(G, E | 32'h400); // pause flag
		repeat (40) @(posedge sys_clk); // wait before reading
		`CHK(cons(32'h40), 1'b1) // mark written
		wr(G, E | 32'h401);
		rd(G, E | 32'h80); // running again
		wait_irq();
		rd(G, E | 32'h100); // list finished
		`CHK(cons(32'h60), 1'b1) // loaded packet ran
		$display("test pause done");
		mkpkt(32'h80, 32'h200, 32'hA0, 1'b0);
		mkpkt(32'hA0, 32'h10, 32'hC0, 1'b1);
		wr(G, E | 32'h3F00);
		wr(P, 32'h80);
		wr(G, E | 32'h1);
		b0 = beats;
		repeat (20) @(posedge sys_clk);
		wr(G, E | 32'h101);
		rd(G, E | 32'h80); // launch ignored
		wr(G, E | 32'h2);
		wait_irq();
		`CHK(dst_req, 1'b0) // queue drained
		rd(G, E | 32'h200); // abort flag
		n = beats - b0;
		rd(`LLD_OFF_COUNT, 32'h200 - 8 * n); // bytes left
		rd(`LLD_OFF_VADDR, 32'h1800 + 8 * n); // next address
		wr(G, E | 32'h201);
		wait_irq();
		rd(G, E | 32'h100); // resumed
		`CHK(cons(32'h80) & cons(32'hA0), 1'b1) // list continued
		$display("test abort done");
		mkpkt(32'hC0, 32'h10, 32'hE0, 1'b1);
		wr(G, E | 32'h3F00);
		wr(L, 32'h1);
		rd(L, 32'h1); // claim granted
		wr(P, 32'hC0);
		rd(P, 32'hC0); // still writable
		wr(G, E | 32'h1);
		repeat (30) @(posedge sys_clk);
		`CHK(mem_req, 1'b0) // stalled at boundary
		wr(L, 32'h0);
		wait_irq();
		`CHK(cons(32'hC0), 1'b1) // fetch after release
		wr(L, 32'h1);
		rd(L, 32'h1); // claim granted again
		mkpkt(32'hE0, 32'h20, 32'h0, 1'b1);
		far.mem_q[52] = 32'hE1;
		wr(L, 32'h0);
		wr(G, E | 32'h101);
		wait_irq();
		rd(G, E | 32'h100); // appended packet ran
		`CHK(cons(32'hE0), 1'b1) // appended packet consumed
		$display("test lock done");
		mkpkt(0, 32'h200, 32'h20, 1'b1);
		wr(G, E | 32'h3F00);
		wr(P, 32'h0);
		wr(G, E | 32'h1);
		repeat (20) @(posedge sys_clk);
		// Errors count only while data moves, so wait for the source side.
		while (src_req !== 1'b1)
			@(posedge sys_clk);
		{err_local, err_vme} <= 2'h3;
		@(posedge sys_clk);
		{err_local, err_vme} <= 2'h0;
		wait_irq();
		rd(G, E | 32'h1800); // error status
		wr(G, E | 32'h101);
		rd(G, E | 32'h1800); // launch refused
		$display("test error done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
